// ### src/kpsd_pkg.sv
// constants, register map and scan states of the keypad scan decoder
// assumes a single 40 MHz clock and a synchronous active high reset
package kpsd_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SETTLE_NS = 1000;
   localparam int unsigned SETTLE_CYC =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 1);
   // ****************************************
   // keypad port layout and segment patterns
   // ****************************************
   localparam logic [7:0] ROW_LINES = 8'h0f;
   localparam logic [7:0] COL_LINES = 8'hf0;
   localparam logic [7:0] NO_KEY = 8'h00;
   localparam logic [7:0] SEG_BLANK = 8'h7f;
   localparam logic [7:0] SEG_ERROR = 8'h30;
   localparam logic [7:0] SEG_RESET = 8'hff;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_RESULT = 4'h3;
   localparam logic [3:0] ADDR_SEGMENT = 4'h4;
   localparam int unsigned CTRL_RUN = 0;
   localparam int unsigned CTRL_IRQ_MODE = 1;
   localparam int unsigned CTRL_ARM = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int unsigned EV_KEY = 0;
   localparam int unsigned EV_INVALID = 1;
   localparam int unsigned EV_WAKE = 2;
   localparam int unsigned EV_W = 3;
   localparam logic [2:0] EV_RESET = 3'h0;
   // ****************************************
   // scan states
   // ****************************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ROWS = 5'b00010,
      ST_COLS = 5'b00100,
      ST_EVAL = 5'b01000,
      ST_WAIT = 5'b10000
   } kpsd_state_type;
endpackage

// ### src/kpsd_dec_if.sv
// carrier between the scan engine and the segment decoder
// assumes both ends are combinational toward each other
`timescale 1ns/1ps
interface kpsd_dec_if;
   logic [7:0] result;
   logic [7:0] seg;
   logic valid;
   logic multi;
   modport engine (output result, input seg, input valid, input multi);
   modport table_end (input result, output seg, output valid, output multi);
endinterface

// ### src/kpsd_decode.sv
// result byte validation and key to segment lookup
// assumes the result byte is stable while it is looked up
`timescale 1ns/1ps
module kpsd_decode
(
   kpsd_dec_if.table_end dec
);
   // ****************************************
   // lookup
   // ****************************************
   // key to segment table, every unlisted index gives the error glyph
   function automatic logic [7:0] key_to_segment_table(input logic [7:0] idx);
      logic [7:0] s;
      s = kpsd_pkg::SEG_ERROR;
      case (idx)
         8'h00: s = kpsd_pkg::SEG_BLANK;
         8'h11: s = 8'h4f;
         8'h12: s = 8'h4c;
         8'h14: s = 8'h0f;
         8'h18: s = 8'h78;
         8'h21: s = 8'h12;
         8'h22: s = 8'h24;
         8'h24: s = 8'h00;
         8'h28: s = 8'h01;
         8'h41: s = 8'h06;
         8'h42: s = 8'h20;
         8'h44: s = 8'h04;
         8'h48: s = 8'h18;
         default: s = kpsd_pkg::SEG_ERROR;
      endcase
      return s;
   endfunction

   // one column nibble bit and one row nibble bit
   assign dec.valid = $onehot(dec.result[7:4]) && $onehot(dec.result[3:0]);
   // anything but clear or one key is a multiple closure
   assign dec.multi = (dec.result != kpsd_pkg::NO_KEY) && !dec.valid;
   assign dec.seg = key_to_segment_table(dec.result);
endmodule

// ### src/kpsd_irq.sv
// sticky event flags, mask and level interrupt
// assumes write strobe and data come straight from the register port
`timescale 1ns/1ps
module kpsd_irq
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [kpsd_pkg::EV_W-1:0] event_set,
   input wire logic clear_wr,
   input wire logic mask_wr,
   input wire logic [kpsd_pkg::EV_W-1:0] wdata,
   output logic [kpsd_pkg::EV_W-1:0] status,
   output logic [kpsd_pkg::EV_W-1:0] mask,
   output logic irq
);
   logic [kpsd_pkg::EV_W-1:0] status_r;
   logic [kpsd_pkg::EV_W-1:0] mask_r;

   // sticky flags, a new event beats a write of one
   always_ff @(posedge clock)
   begin
      if (rst)
         status_r <= kpsd_pkg::EV_RESET;
      else if (ce)
         status_r <= (status_r & ~(clear_wr ? wdata : kpsd_pkg::EV_RESET))
                     | event_set;
   end

   // interrupt mask
   always_ff @(posedge clock)
   begin
      if (rst)
         mask_r <= kpsd_pkg::EV_RESET;
      else if (ce && mask_wr)
         mask_r <= wdata;
   end

   assign status = status_r;
   assign mask = mask_r;
   assign irq = |(status_r & mask_r);
endmodule

// ### src/kpsd_top.sv
// keypad scan decoder: two phase 4x4 scan, debounce, segment display
// assumes keypad lines are pulled down outside and inputs are synchronous
//
// Overview of operation
// - phase one drives the row lines high, columns float low, samples all.
// - phase two drives the column lines high, rows float low, samples all.
// - scan result is the bitwise AND of both phase samples.
// - upper nibble gives the column, lower nibble gives the row.
// - no key closed gives a result of all zeros.
// - valid press needs exactly one column bit and one row bit.
// - every other nonzero pattern is a multiple closure, flagged invalid.
// - lookup table turns result into segments; invalid gives error glyph.
// - polled scanning repeats and each accepted result feeds the display lines.
// - segment lines are active low for a common anode display.
// - all segments low shows eight, all high blanks the display.
// - keypad lines only drive high or release; display drives strongly.
// - a result counts only after two consecutive identical scans.
// - in interrupt mode rising row edges raise the wake event.
// - while waiting for a key the column lines stay driven high.
// - a row wake starts a full two phase scan.
// - rows sit low until a key joins a driven column to them.
// - row wake is armed only after column drive has settled.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module kpsd_top
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [7:0] keypad_port_data_in,
   output logic [7:0] keypad_port_data_out,
   output logic [7:0] keypad_port_data_oe,
   output logic [7:0] display_port_data,
   output logic [7:0] display_port_data_oe,
   output logic irq
);
   // ****************************************
   // declarations
   // ****************************************
   kpsd_pkg::kpsd_state_type state_r;
   kpsd_pkg::kpsd_state_type state_nxt;
   logic [5:0] cnt_r;
   logic settle_done;
   logic [7:0] phase_a_r;
   logic [7:0] phase_b_r;
   logic [7:0] prev_scan_r;
   logic [7:0] accepted_r;
   logic [7:0] seg_r;
   logic [7:0] drive_r;
   logic [7:0] drive_nxt;
   logic [3:0] rows_prev_r;
   logic [2:0] ctrl_r;
   logic [7:0] rdata_r;
   logic [7:0] scan_res;
   logic stable;
   logic accept;
   logic armed;
   logic wake;
   logic [kpsd_pkg::EV_W-1:0] events;
   logic [kpsd_pkg::EV_W-1:0] status;
   logic [kpsd_pkg::EV_W-1:0] mask;
   logic ctrl_wr;

   kpsd_dec_if dec();

   // ****************************************
   // register port
   // ****************************************
   // write decode for the control word
   assign ctrl_wr = wr && (addr == kpsd_pkg::ADDR_CTRL);

   // control bits: run, interrupt mode, row wake arm
   always_ff @(posedge clock)
   begin
      if (rst)
         ctrl_r <= kpsd_pkg::CTRL_RESET;
      else if (ce && ctrl_wr)
         ctrl_r <= wdata[2:0];
   end

   // read data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clock)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (ce)
      begin
         rdata_r <= 8'h00;
         if (rd)
         begin
            case (addr)
               kpsd_pkg::ADDR_CTRL: rdata_r <= {5'h00, ctrl_r};
               kpsd_pkg::ADDR_STATUS: rdata_r <= {5'h00, status};
               kpsd_pkg::ADDR_MASK: rdata_r <= {5'h00, mask};
               kpsd_pkg::ADDR_RESULT: rdata_r <= accepted_r;
               kpsd_pkg::ADDR_SEGMENT: rdata_r <= seg_r;
               default: rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign rdata = rdata_r;

   // ****************************************
   // event flags and interrupt
   // ****************************************
   kpsd_irq u_irq
   (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .event_set(events),
      .clear_wr(wr && (addr == kpsd_pkg::ADDR_STATUS)),
      .mask_wr(wr && (addr == kpsd_pkg::ADDR_MASK)),
      .wdata(wdata[kpsd_pkg::EV_W-1:0]),
      .status(status),
      .mask(mask),
      .irq(irq)
   );

   // ****************************************
   // decoder
   // ****************************************
   // combined phase samples, column nibble high, row nibble low
   assign scan_res = phase_a_r & phase_b_r;
   assign dec.result = scan_res;

   kpsd_decode u_decode
   (
      .dec(dec)
   );

   // ****************************************
   // scan sequencing
   // ****************************************
   // settle counter saturates at the last count
   assign settle_done = (cnt_r == kpsd_pkg::SETTLE_LAST);
   // two identical scans in a row
   assign stable = (scan_res == prev_scan_r);
   // new debounced result that differs from the shown one
   assign accept = (state_r == kpsd_pkg::ST_EVAL) && stable
                   && (scan_res != accepted_r);
   // wake armed only once columns have settled and software armed it
   assign armed = (state_r == kpsd_pkg::ST_WAIT) && settle_done
                  && ctrl_r[kpsd_pkg::CTRL_ARM];
   // rising row level while armed
   assign wake = armed
                 && (|(keypad_port_data_in[3:0] & ~rows_prev_r));

   // next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         kpsd_pkg::ST_IDLE:
         begin
            if (ctrl_r[kpsd_pkg::CTRL_RUN])
               state_nxt = kpsd_pkg::ST_ROWS;
         end
         kpsd_pkg::ST_ROWS:
         begin
            if (settle_done)
               state_nxt = kpsd_pkg::ST_COLS;
         end
         kpsd_pkg::ST_COLS:
         begin
            if (settle_done)
               state_nxt = kpsd_pkg::ST_EVAL;
         end
         kpsd_pkg::ST_EVAL:
         begin
            if (!ctrl_r[kpsd_pkg::CTRL_RUN])
               state_nxt = kpsd_pkg::ST_IDLE;
            else if (ctrl_r[kpsd_pkg::CTRL_IRQ_MODE] && stable)
               state_nxt = kpsd_pkg::ST_WAIT;
            else
               state_nxt = kpsd_pkg::ST_ROWS;
         end
         kpsd_pkg::ST_WAIT:
         begin
            if (!ctrl_r[kpsd_pkg::CTRL_RUN])
               state_nxt = kpsd_pkg::ST_IDLE;
            else if (wake || !ctrl_r[kpsd_pkg::CTRL_IRQ_MODE])
               state_nxt = kpsd_pkg::ST_ROWS;
         end
         default: state_nxt = kpsd_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (rst)
         state_r <= kpsd_pkg::ST_IDLE;
      else if (ce)
         state_r <= state_nxt;
   end

   // settle counter restarts on every state change
   always_ff @(posedge clock)
   begin
      if (rst)
         cnt_r <= 6'h00;
      else if (ce)
      begin
         if (state_nxt != state_r)
            cnt_r <= 6'h00;
         else if (!settle_done)
            cnt_r <= cnt_r + 6'h01;
      end
   end

   // ****************************************
   // keypad line drive
   // ****************************************
   // lines are only driven high or released to the pull-downs
   always_comb
   begin
      drive_nxt = 8'h00;
      case (state_nxt)
         kpsd_pkg::ST_ROWS: drive_nxt = kpsd_pkg::ROW_LINES;
         kpsd_pkg::ST_COLS: drive_nxt = kpsd_pkg::COL_LINES;
         kpsd_pkg::ST_WAIT: drive_nxt = kpsd_pkg::COL_LINES;
         default: drive_nxt = 8'h00;
      endcase
   end

   // registered drive pattern
   always_ff @(posedge clock)
   begin
      if (rst)
         drive_r <= 8'h00;
      else if (ce)
         drive_r <= drive_nxt;
   end

   assign keypad_port_data_out = drive_r;
   assign keypad_port_data_oe = drive_r;

   // ****************************************
   // sampling and debounce
   // ****************************************
   // phase samples at the end of each settle time
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         phase_a_r <= kpsd_pkg::NO_KEY;
         phase_b_r <= kpsd_pkg::NO_KEY;
      end
      else if (ce)
      begin
         if ((state_r == kpsd_pkg::ST_ROWS) && settle_done)
            phase_a_r <= keypad_port_data_in;
         if ((state_r == kpsd_pkg::ST_COLS) && settle_done)
            phase_b_r <= keypad_port_data_in;
      end
   end

   // previous scan for the two scan agreement
   always_ff @(posedge clock)
   begin
      if (rst)
         prev_scan_r <= kpsd_pkg::NO_KEY;
      else if (ce && (state_r == kpsd_pkg::ST_EVAL))
         prev_scan_r <= scan_res;
   end

   // row history for edge detection while waiting
   always_ff @(posedge clock)
   begin
      if (rst)
         rows_prev_r <= 4'hf;
      else if (ce)
         rows_prev_r <= keypad_port_data_in[3:0];
   end

   // ****************************************
   // display
   // ****************************************
   // accepted result and its segments, held until a new one
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         accepted_r <= kpsd_pkg::NO_KEY;
         seg_r <= kpsd_pkg::SEG_RESET;
      end
      else if (ce && accept)
      begin
         accepted_r <= scan_res;
         seg_r <= dec.seg;
      end
   end

   // active low segments, strongly driven
   assign display_port_data = seg_r;
   assign display_port_data_oe = 8'hff;

   // events for the flag register
   always_comb
   begin
      events = kpsd_pkg::EV_RESET;
      events[kpsd_pkg::EV_KEY] = ce && accept;
      events[kpsd_pkg::EV_INVALID] = ce && accept && dec.multi;
      events[kpsd_pkg::EV_WAKE] = ce && wake;
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_rows_end;
      (state_r == kpsd_pkg::ST_ROWS) && settle_done;
   endsequence

   sequence s_cols_end;
      (state_r == kpsd_pkg::ST_COLS) && settle_done;
   endsequence

   property p_rows_drive;
      @(posedge clock) disable iff (rst || !ce)
      (state_r == kpsd_pkg::ST_ROWS) |->
         (keypad_port_data_oe == 8'h0f) && (keypad_port_data_out == 8'h0f);
   endproperty
   a_rows_drive: assert property (p_rows_drive)
      else $error("rows not driven in phase one");

   property p_cols_drive;
      @(posedge clock) disable iff (rst || !ce)
      (state_r == kpsd_pkg::ST_COLS) |->
         (keypad_port_data_oe == 8'hf0) && (keypad_port_data_out == 8'hf0);
   endproperty
   a_cols_drive: assert property (p_cols_drive)
      else $error("columns not driven in phase two");

   property p_rows_sample;
      @(posedge clock) disable iff (rst || !ce)
      s_rows_end |=> (phase_a_r == $past(keypad_port_data_in));
   endproperty
   a_rows_sample: assert property (p_rows_sample)
      else $error("phase one lines not sampled at settle end");

   property p_and_result;
      @(posedge clock) disable iff (rst || !ce)
      s_cols_end
      |=> (scan_res == ($past(keypad_port_data_in) & phase_a_r));
   endproperty
   a_and_result: assert property (p_and_result)
      else $error("scan result is not the AND of both phases");

   property p_multi_error;
      @(posedge clock) disable iff (rst || !ce)
      accept && dec.multi |=> (display_port_data == 8'h30);
   endproperty
   a_multi_error: assert property (p_multi_error)
      else $error("multiple closure not shown as error");

   property p_blank;
      @(posedge clock) disable iff (rst || !ce)
      accept && (scan_res == 8'h00) |=> (display_port_data == 8'h7f);
   endproperty
   a_blank: assert property (p_blank)
      else $error("no key did not blank the display");

   property p_debounce;
      @(posedge clock) disable iff (rst || !ce)
      (state_r == kpsd_pkg::ST_EVAL) && (scan_res != prev_scan_r)
      |=> $stable(display_port_data) && $stable(accepted_r);
   endproperty
   a_debounce: assert property (p_debounce)
      else $error("display changed on a single scan");

   property p_hold;
      @(posedge clock) disable iff (rst || !ce)
      !accept |=> $stable(display_port_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("display changed without a new result");

   property p_wait_cols;
      @(posedge clock) disable iff (rst || !ce)
      (state_r == kpsd_pkg::ST_WAIT) |-> (keypad_port_data_oe == 8'hf0);
   endproperty
   a_wait_cols: assert property (p_wait_cols)
      else $error("columns released while waiting");

   property p_wake_scan;
      @(posedge clock) disable iff (rst || !ce)
      wake && ctrl_r[kpsd_pkg::CTRL_RUN] |=> (state_r == kpsd_pkg::ST_ROWS)
         ##[40:40] (state_r == kpsd_pkg::ST_COLS);
   endproperty
   a_wake_scan: assert property (p_wake_scan)
      else $error("row wake did not start a full scan");

   property p_arm_late;
      @(posedge clock) disable iff (rst || !ce)
      (state_r == kpsd_pkg::ST_WAIT) && !settle_done |-> !wake;
   endproperty
   a_arm_late: assert property (p_arm_late)
      else $error("row wake armed before columns settled");
endmodule

// ### testbench/kpsd_keypad_model.sv
// passive 4x4 switch matrix hung on the keypad port
// assumes the design drives lines high only, every line has a pull-down
`timescale 1ns/1ps
module kpsd_keypad_model
(
   input wire logic [15:0] key_closed,
   input wire logic [7:0] line_out,
   input wire logic [7:0] line_oe,
   output logic [7:0] line_in
);
   // closed switch k joins row k%4 to column k/4; undriven lines read low
   always_comb
   begin
      line_in = line_out & line_oe;
      for (int p = 0; p < 3; p++)
      begin
         for (int k = 0; k < 16; k++)
         begin
            if (key_closed[k] && (line_in[4 + k / 4] || line_in[k % 4]))
            begin
               line_in[4 + k / 4] = 1'b1;
               line_in[k % 4] = 1'b1;
            end
         end
      end
   end
endmodule

// ### testbench/tb_kpsd_top.sv
// self-checking bench for the keypad scan decoder
// assumes the switch matrix model on the keypad port, ce held high
`timescale 1ns/1ps
module tb_kpsd_top;
   // ****************************************
   // signals and instances
   // ****************************************
   logic clock;
   logic rst;
   logic ce;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic [7:0] kp_in;
   logic [7:0] kp_out;
   logic [7:0] kp_oe;
   logic [7:0] disp;
   logic [7:0] disp_oe;
   logic irq;
   logic [15:0] key_closed;
   logic [7:0] exp_res;
   logic [7:0] prev_res;
   logic [7:0] prev_seg;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   kpsd_top i_kpsd_top
   (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .keypad_port_data_in(kp_in),
      .keypad_port_data_out(kp_out),
      .keypad_port_data_oe(kp_oe),
      .display_port_data(disp),
      .display_port_data_oe(disp_oe),
      .irq(irq)
   );

   kpsd_keypad_model i_kpsd_keypad_model
   (
      .key_closed(key_closed),
      .line_out(kp_out),
      .line_oe(kp_oe),
      .line_in(kp_in)
   );

   // 40 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // hang guard, well above the expected run length
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   // ****************************************
   // helper tasks
   // ****************************************
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask

   // one-cycle write, then one idle cycle
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic reg_chk(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      cmp_byte(rdata, e);
      @(posedge clock);
   endtask

   // expected segment pattern for a result byte
   function automatic logic [7:0] seg_of(input logic [7:0] r);
      case (r)
         8'h00: seg_of = 8'h7f;
         8'h11: seg_of = 8'h4f;
         8'h12: seg_of = 8'h4c;
         8'h14: seg_of = 8'h0f;
         8'h18: seg_of = 8'h78;
         8'h21: seg_of = 8'h12;
         8'h22: seg_of = 8'h24;
         8'h24: seg_of = 8'h00;
         8'h28: seg_of = 8'h01;
         8'h41: seg_of = 8'h06;
         8'h42: seg_of = 8'h20;
         8'h44: seg_of = 8'h04;
         8'h48: seg_of = 8'h18;
         default: seg_of = 8'h30;
      endcase
   endfunction

   // wait for a fresh scan start, checking both drive patterns
   task automatic scan_sync();
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (kp_oe !== 8'hf0 && n < 200);
      cmp_byte(kp_out, 8'hf0);
      do
      begin
         @(posedge clock);
         n++;
      end
      while (kp_oe !== 8'h0f && n < 400);
      cmp_byte(kp_out, 8'h0f);
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      key_closed = 16'h0000;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      cmp_byte(disp, 8'hff);
      cmp_byte(disp_oe, 8'hff);
      cmp_byte(kp_oe, 8'h00);
      cmp_bit(irq, 1'b0);
      reg_chk(kpsd_pkg::ADDR_CTRL, 8'h00);
      reg_chk(kpsd_pkg::ADDR_STATUS, 8'h00);
      reg_chk(kpsd_pkg::ADDR_MASK, 8'h00);
      reg_chk(4'hf, 8'h00);
      // polled scanning, two keys in one column first
      reg_wr(kpsd_pkg::ADDR_CTRL, 8'h01);
      key_closed <= 16'h0003;
      repeat (250) @(posedge clock);
      reg_chk(kpsd_pkg::ADDR_RESULT, 8'h13);
      cmp_byte(disp, 8'h30);
      reg_chk(kpsd_pkg::ADDR_STATUS, 8'h03);
      reg_wr(kpsd_pkg::ADDR_MASK, 8'h00);
      cmp_bit(irq, 1'b0);
      reg_wr(kpsd_pkg::ADDR_MASK, 8'h07);
      cmp_bit(irq, 1'b1);
      reg_chk(kpsd_pkg::ADDR_MASK, 8'h07);
      reg_wr(kpsd_pkg::ADDR_STATUS, 8'h07);
      cmp_bit(irq, 1'b0);
      prev_res = 8'h13;
      prev_seg = 8'h30;
      // every single key, changed right at a scan start
      for (int k = 0; k < 16; k++)
      begin
         exp_res = (8'h10 << (k / 4)) | (8'h01 << (k % 4));
         scan_sync();
         key_closed <= 16'h0001 << k;
         repeat (100) @(posedge clock);
         reg_chk(kpsd_pkg::ADDR_RESULT, prev_res);
         reg_chk(kpsd_pkg::ADDR_STATUS, 8'h00);
         cmp_byte(disp, prev_seg);
         repeat (70) @(posedge clock);
         reg_chk(kpsd_pkg::ADDR_RESULT, exp_res);
         cmp_byte(disp, seg_of(exp_res));
         reg_chk(kpsd_pkg::ADDR_SEGMENT, seg_of(exp_res));
         reg_chk(kpsd_pkg::ADDR_STATUS, 8'h01);
         cmp_bit(irq, 1'b1);
         reg_wr(kpsd_pkg::ADDR_STATUS, 8'h07);
         prev_res = exp_res;
         prev_seg = seg_of(exp_res);
      end
      key_closed <= 16'h0000;
      repeat (250) @(posedge clock);
      reg_chk(kpsd_pkg::ADDR_RESULT, 8'h00);
      cmp_byte(disp, 8'h7f);
      // interrupt mode, wake not armed yet
      reg_wr(kpsd_pkg::ADDR_STATUS, 8'h07);
      reg_wr(kpsd_pkg::ADDR_CTRL, 8'h03);
      repeat (300) @(posedge clock);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clock);
         cmp_byte(kp_oe, 8'hf0);
      end
      cmp_byte(kp_out, 8'hf0);
      key_closed <= 16'h0040;
      repeat (100) @(posedge clock);
      reg_chk(kpsd_pkg::ADDR_STATUS, 8'h00);
      cmp_byte(kp_oe, 8'hf0);
      // armed: a fresh row edge wakes a full scan
      key_closed <= 16'h0000;
      reg_wr(kpsd_pkg::ADDR_CTRL, 8'h07);
      repeat (60) @(posedge clock);
      key_closed <= 16'h0040;
      repeat (4) @(posedge clock);
      reg_chk(kpsd_pkg::ADDR_STATUS, 8'h04);
      cmp_byte(kp_oe, 8'h0f);
      repeat (200) @(posedge clock);
      reg_chk(kpsd_pkg::ADDR_RESULT, 8'h24);
      cmp_byte(disp, 8'h00);
      reg_chk(kpsd_pkg::ADDR_STATUS, 8'h05);
      print_verdict();
   end
endmodule
